// ==== mps_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_mem_model
  import mps_pkg::*;
(
  input  wire logic            clk,
  input  wire logic [PC_W-1:0] pm_addr,
  input  wire mps_ram_t        ram,
  output logic [IW-1:0]        pm_data,
  output logic [DW-1:0]        ram_rdata
);
  logic [DW-1:0] b0 [128];
  logic [DW-1:0] b1 [128];

  // program words are a fixed pattern of their own address, so no load is needed
  assign pm_data = {pm_addr[2:0] ^ 3'h5, pm_addr};

  // asynchronous read of the selected bank
  assign ram_rdata = ram.bank ? b1[ram.addr] : b0[ram.addr];

  // write on the edge where the strobe stands
  always_ff @(posedge clk)
  begin
    if (ram.we && ram.bank)
      b1[ram.addr] <= ram.wdata;
    else if (ram.we)
      b0[ram.addr] <= ram.wdata;
  end
endmodule
`default_nettype wire

// ==== mps_pkg.sv ====
`default_nettype none
package mps_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W        = 12;
  localparam int DA_W        = 7;
  localparam int DW          = 8;
  localparam int IW          = 15;
  localparam int IRQ_N       = 4;
  localparam int STACK_DEPTH = 4;

  // ----------------------------------------------------------------
  // program counter vectors and steps
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [PC_W-1:0] VEC_EXT   = 12'h004;
  localparam logic [PC_W-1:0] VEC_TMR0  = 12'h008;
  localparam logic [PC_W-1:0] VEC_TMR1  = 12'h00C;
  localparam logic [PC_W-1:0] VEC_CONV  = 12'h010;
  localparam logic [PC_W-1:0] PC_ONE    = 12'h001;
  localparam logic [3:0]      LAST_PAGE = 4'hF;

  // ----------------------------------------------------------------
  // data address map
  // ----------------------------------------------------------------
  localparam logic [DA_W-1:0] A_IND0    = 7'h00;
  localparam logic [DA_W-1:0] A_MP0     = 7'h01;
  localparam logic [DA_W-1:0] A_IND1    = 7'h02;
  localparam logic [DA_W-1:0] A_MP1     = 7'h03;
  localparam logic [DA_W-1:0] A_BANK    = 7'h04;
  localparam logic [DA_W-1:0] A_WREG    = 7'h05;
  localparam logic [DA_W-1:0] A_PCL     = 7'h06;
  localparam logic [DA_W-1:0] A_TABLE_POINTER    = 7'h07;
  localparam logic [DA_W-1:0] A_TABLE_HIGH_LATCH    = 7'h08;
  localparam logic [DA_W-1:0] A_RAM_LO  = 7'h20;
  localparam logic [DA_W-1:0] A_DISP_LO = 7'h40;
  localparam logic [DA_W-1:0] A_DISP_HI = 7'h50;
  localparam logic [DW-1:0]   BANK_DISP = 8'h01;
  localparam logic [DW-1:0]   ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // phases and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PH_FIRST  = 2'h0;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST   = 2'h3;
  localparam logic [1:0] PH_STEP   = 2'h1;
  localparam int SST_TSYS = 1024;   // start-up time in system clock periods
  localparam int CLK_PER_TSYS = 1;  // clk runs at the system clock rate
  localparam int SST_CYC  = SST_TSYS * CLK_PER_TSYS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE     = 3'h0,
    OP_JUMP     = 3'h1,
    OP_CALL     = 3'h2,
    OP_RET      = 3'h3,
    OP_RETURN_FROM_INTERRUPT     = 3'h4,
    OP_SKIP     = 3'h5,
    OP_TRD_CUR  = 3'h6,
    OP_TRD_LAST = 3'h7
  } mps_op_t;

  typedef struct packed {
    mps_op_t         op;
    logic [PC_W-1:0] target;
    logic            rd;
    logic            wr;
    logic [DA_W-1:0] daddr;
    logic [DW-1:0]   wdata;
  } mps_cmd_t;

  typedef struct packed {
    logic            bank;
    logic [DA_W-1:0] addr;
    logic            we;
    logic [DW-1:0]   wdata;
  } mps_ram_t;

  typedef struct packed {
    logic            nul;
    logic            bank;
    logic [DA_W-1:0] ea;
  } mps_ea_t;

  typedef struct packed {
    logic [1:0]       phase;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  pm_addr;
    logic [IW-1:0]    instr;
    logic             instr_valid;
    logic [IW-1:0]    hold;
    logic             tbl_busy;
    logic [DA_W-1:0]  tbl_dst;
    logic [DA_W-1:0]  mp0;
    logic [DA_W-1:0]  mp1;
    logic [DW-1:0]    bp;
    logic [DW-1:0]    wreg;
    logic [DW-1:0]    table_pointer;
    logic [DW-1:0]    table_high_latch;
    logic [DW-1:0]    rd_data;
    logic [IRQ_N-1:0] irq_ack;
    mps_ram_t         ram;
  } mps_seq_t;

endpackage
`default_nettype wire

// ==== mps_seq_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_seq_properties
  import mps_pkg::*;
#(
  parameter int SST_CYCLES = SST_CYC
)
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic             wake,
  input wire mps_cmd_t         cmd,
  input wire logic [IRQ_N-1:0] irq_pend,
  input wire logic [PC_W-1:0]  pm_addr,
  input wire logic             instr_valid,
  input wire logic [1:0]       phase,
  input wire logic             running,
  input wire logic [IRQ_N-1:0] irq_ack,
  input wire mps_ram_t         ram
);
  logic [15:0] hold_ff;
  logic        bnd;

  // enabled edges since reset or wake, saturating so it cannot wrap
  always_ff @(posedge clk)
  begin
    if (!rst_n || (ce && wake))
      hold_ff <= 16'h0000;
    else if (ce && hold_ff < 16'(SST_CYCLES))
      hold_ff <= hold_ff + 16'h0001;
  end

  // a valid instruction at its last phase
  assign bnd = running && ce && phase == PH_LAST && instr_valid;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_hold; running == (hold_ff >= 16'(SST_CYCLES)); endproperty
  property p_rst; $rose(rst_n) |-> pm_addr == VEC_RESET && !running && !instr_valid; endproperty
  property p_phase; running && $past(running) && ce |=> phase == $past(phase) + 2'h1; endproperty
  property p_fetch;
    bnd && cmd.op == OP_NONE && !cmd.wr && irq_pend == 4'h0 |=> pm_addr == $past(pm_addr) + PC_ONE && instr_valid;
  endproperty
  property p_skip; bnd && cmd.op == OP_SKIP |=> pm_addr == $past(pm_addr) + PC_ONE && !instr_valid; endproperty
  property p_jump; bnd && cmd.op inside {OP_JUMP, OP_CALL} |=> pm_addr == $past(cmd.target) && !instr_valid; endproperty
  property p_last; bnd && cmd.op == OP_TRD_LAST |=> pm_addr[11:8] == LAST_PAGE && !instr_valid; endproperty
  property p_prio;
    irq_ack != 4'h0 |-> irq_ack == ($past(irq_pend) & ~($past(irq_pend) - 4'h1)) && $past(phase) == PH_LAST;
  endproperty
  property p_vec;
    irq_ack != 4'h0 |-> !instr_valid
      && pm_addr == (irq_ack[0] ? VEC_EXT : irq_ack[1] ? VEC_TMR0 : irq_ack[2] ? VEC_TMR1 : VEC_CONV);
  endproperty
  property p_we; ram.we |-> ram.addr >= A_RAM_LO ##1 !ram.we; endproperty
  property p_bank; ram.we && ram.bank |-> ram.addr >= A_DISP_LO && ram.addr <= A_DISP_HI; endproperty

  a_hold: assert property (p_hold) else $error("start-up hold length wrong");
  a_rst: assert property (p_rst) else $error("reset address wrong");
  a_phase: assert property (p_phase) else $error("phase did not step");
  a_fetch: assert property (p_fetch) else $error("fetch did not advance by one");
  a_skip: assert property (p_skip) else $error("skip not handled");
  a_jump: assert property (p_jump) else $error("branch target or dummy wrong");
  a_last: assert property (p_last) else $error("last page table address wrong");
  a_prio: assert property (p_prio) else $error("interrupt priority wrong");
  a_vec: assert property (p_vec) else $error("interrupt vector wrong");
  a_we: assert property (p_we) else $error("array write outside data memory");
  a_bank: assert property (p_bank) else $error("display bank write out of range");

  c_irq: cover property (irq_ack != 4'h0);
  c_skip: cover property (bnd && cmd.op == OP_SKIP);
  c_disp: cover property (ram.we && ram.bank);
endmodule
bind mps_sequencer mps_seq_properties #(.SST_CYCLES(SST_CYCLES)) u_props (.clk, .rst_n, .ce, .wake, .cmd, .irq_pend,
  .pm_addr, .instr_valid, .phase, .running, .irq_ack, .ram);
`default_nettype wire

// ==== mps_sequencer.sv ====
// Function
// - instruction cycle is four phases, one clock each
// - fetch overlaps execute; counter-changing instructions take two cycles
// - program counter is 12 bits, 4096 words
// - counter advances by one after each fetch
// - true skip discards prefetched word, dummy cycle, counter plus two
// - counter low byte at 06H; writing it jumps within the page
// - reset loads counter with 000H
// - interrupt vectors 004H, 008H, 00CH for external and timers
// - converter-done interrupt vectors to 010H
// - table address: page bits from counter or all ones, low from pointer
// - table low byte to data location, upper bits to latch 08H; pointer 07H
// - table reads take two instruction cycles
// - four-level hidden stack; push on call or interrupt, pop on return
// - stack full withholds interrupt acknowledge until a return
// - call on full stack drops the oldest entry
// - unimplemented addresses below 20H read 00H
// - general data memory is 20H to 7FH
// - bank 1 display memory only via second pointer, 40H to 50H
// - addresses 00H and 02H access through the two pointers
// - indirect access onto an indirect address reads 00H, writes nothing
// - pointers are 7 bits; only the second reaches display memory
// - hold execution 1024 system clocks after power-up or wake-up
// - pending interrupts served external, timer 0, timer 1, converter
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int SST_CYCLES   = SST_CYC,
  parameter int STACK_LEVELS = STACK_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             wake,
  input  wire mps_cmd_t         cmd,
  input  wire logic [IRQ_N-1:0] irq_pend,
  input  wire logic [IW-1:0]    pm_data,
  input  wire logic [DW-1:0]    ram_rdata,
  output logic [PC_W-1:0]       pm_addr,
  output logic [IW-1:0]         instr,
  output logic                  instr_valid,
  output logic [1:0]            phase,
  output logic                  running,
  output logic [DW-1:0]         rd_data,
  output logic [IRQ_N-1:0]      irq_ack,
  output mps_ram_t              ram
);

  // ----------------------------------------------------------------
  // state and stack hookup
  // ----------------------------------------------------------------
  mps_seq_t        s_ff;
  mps_seq_t        nxt_s;
  logic            stk_push;
  logic            stk_pop;
  logic [PC_W-1:0] stk_top;
  logic            stk_full;
  logic            sst_done;

  mps_stack #(
    .DEPTH (STACK_LEVELS)
  ) u_stack (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .push  (stk_push),
    .pop   (stk_pop),
    .din   (s_ff.pc),
    .top   (stk_top),
    .full  (stk_full)
  );

  // wake from halt restarts the same hold as power-up
  mps_sst #(
    .CYCLES (SST_CYCLES)
  ) u_sst (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .start (wake),
    .done  (sst_done)
  );

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  // both pointers are 7 bits; only the second may reach display memory
  function automatic mps_ea_t resolve(
    input logic [DA_W-1:0] a,
    input logic [DA_W-1:0] m0,
    input logic [DA_W-1:0] m1,
    input logic [DW-1:0]   b
  );
    mps_ea_t r;
    logic    ind;
    r.nul  = 1'b0;
    r.bank = 1'b0;
    r.ea   = a;
    ind    = (a == A_IND0) || (a == A_IND1);
    if (a == A_IND0)
      r.ea = m0;
    else if (a == A_IND1)
    begin
      r.ea   = m1;
      r.bank = (b == BANK_DISP) && (m1 >= A_DISP_LO) && (m1 <= A_DISP_HI);
    end
    if (ind && ((r.ea == A_IND0) || (r.ea == A_IND1)))
      r.nul = 1'b1;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [DW-1:0] read_val(
    input mps_seq_t      st,
    input mps_ea_t       e,
    input logic [DW-1:0] rdat
  );
    logic [DW-1:0]   v;
    logic [PC_W-1:0] cur;
    v   = ZERO_BYTE;
    cur = st.pc - PC_ONE;  // pc already points at the prefetched word
    if (e.nul)
      v = ZERO_BYTE;
    else if (e.ea >= A_RAM_LO)
      v = rdat;
    else
    begin
      case (e.ea)
        A_MP0:   v = {1'b0, st.mp0};
        A_MP1:   v = {1'b0, st.mp1};
        A_BANK:  v = st.bp;
        A_WREG:  v = st.wreg;
        A_PCL:   v = cur[DW-1:0];
        A_TABLE_POINTER:  v = st.table_pointer;
        A_TABLE_HIGH_LATCH:  v = st.table_high_latch;
        default: v = ZERO_BYTE;
      endcase
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // write path; counter low byte is handled by the caller
  // ----------------------------------------------------------------
  function automatic mps_seq_t write_val(
    input mps_seq_t      st,
    input mps_ea_t       e,
    input logic [DW-1:0] d
  );
    mps_seq_t r;
    r = st;
    if (!e.nul)
    begin
      if (e.ea >= A_RAM_LO)
      begin
        r.ram.we    = 1'b1;
        r.ram.addr  = e.ea;
        r.ram.bank  = e.bank;
        r.ram.wdata = d;
      end
      else
      begin
        case (e.ea)
          A_MP0:   r.mp0  = d[DA_W-1:0];
          A_MP1:   r.mp1  = d[DA_W-1:0];
          A_BANK:  r.bp   = d;
          A_WREG:  r.wreg = d;
          A_TABLE_POINTER:  r.table_pointer = d;
          default: r.bp   = r.bp;  // latch at 08H is read-only
        endcase
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  mps_ea_t         ea_now;
  mps_ea_t         ea_tbl;
  logic            xfer;
  logic [PC_W-1:0] xfer_pc;
  logic            pcl_wr;
  logic            irq_ok;
  logic [PC_W-1:0] vec;
  logic [IRQ_N-1:0] ack;
  logic [PC_W-1:0] tbl_addr;

  always_comb
  begin
    nxt_s       = s_ff;
    nxt_s.ram.we  = 1'b0;
    nxt_s.irq_ack = '0;
    stk_push    = 1'b0;
    stk_pop     = 1'b0;
    xfer        = 1'b0;
    xfer_pc     = s_ff.pc;
    vec         = VEC_EXT;
    ack         = '0;
    irq_ok      = 1'b0;
    ea_now      = resolve(cmd.daddr, s_ff.mp0, s_ff.mp1, s_ff.bp);
    ea_tbl      = resolve(s_ff.tbl_dst, s_ff.mp0, s_ff.mp1, s_ff.bp);
    pcl_wr      = cmd.wr && !ea_now.nul && (ea_now.ea == A_PCL);
    tbl_addr    = {((cmd.op == OP_TRD_LAST) ? LAST_PAGE : s_ff.pc[PC_W-1:DW]), s_ff.table_pointer};

    // fixed priority among pending interrupts
    if (irq_pend[0])
    begin
      vec = VEC_EXT;
      ack = 4'h1;
    end
    else if (irq_pend[1])
    begin
      vec = VEC_TMR0;
      ack = 4'h2;
    end
    else if (irq_pend[2])
    begin
      vec = VEC_TMR1;
      ack = 4'h4;
    end
    else if (irq_pend[3])
    begin
      vec = VEC_CONV;
      ack = 4'h8;
    end

    // execution is frozen during the start-up hold
    if (sst_done)
    begin
      nxt_s.phase = s_ff.phase + PH_STEP;

      // address goes out early so the array has two phases to answer
      if (s_ff.phase == PH_FIRST)
      begin
        nxt_s.ram.addr = s_ff.tbl_busy ? ea_tbl.ea : ea_now.ea;
        nxt_s.ram.bank = s_ff.tbl_busy ? ea_tbl.bank : ea_now.bank;
      end

      if ((s_ff.phase == PH_SAMPLE) && s_ff.instr_valid && cmd.rd)
        nxt_s.rd_data = read_val(s_ff, ea_now, ram_rdata);

      // instruction boundary
      if (s_ff.phase == PH_LAST)
      begin
        nxt_s.instr       = pm_data;
        nxt_s.instr_valid = 1'b1;
        nxt_s.pc          = s_ff.pc + PC_ONE;
        nxt_s.pm_addr     = s_ff.pc + PC_ONE;

        if (s_ff.tbl_busy)
        begin
          // second cycle of a table read: the bus carried the table word
          nxt_s             = write_val(nxt_s, ea_tbl, pm_data[DW-1:0]);
          nxt_s.table_high_latch        = {1'b0, pm_data[IW-1:DW]};
          nxt_s.instr       = s_ff.hold;
          nxt_s.instr_valid = 1'b1;
          nxt_s.pc          = s_ff.pc;
          nxt_s.pm_addr     = s_ff.pc;
          nxt_s.tbl_busy    = 1'b0;
        end
        else if (s_ff.instr_valid)
        begin
          if (cmd.wr)
            nxt_s = write_val(nxt_s, ea_now, cmd.wdata);
          if (pcl_wr)
          begin
            xfer    = 1'b1;
            xfer_pc = {s_ff.pc[PC_W-1:DW], cmd.wdata};
          end
          case (cmd.op)
            OP_JUMP:
            begin
              xfer    = 1'b1;
              xfer_pc = cmd.target;
            end
            OP_CALL:
            begin
              stk_push = 1'b1;
              xfer     = 1'b1;
              xfer_pc  = cmd.target;
            end
            OP_RET, OP_RETURN_FROM_INTERRUPT:
            begin
              stk_pop = 1'b1;
              xfer    = 1'b1;
              xfer_pc = stk_top;
            end
            OP_SKIP:
              nxt_s.instr_valid = 1'b0;
            OP_TRD_CUR, OP_TRD_LAST:
            begin
              // park the prefetched word while the bus serves the table
              nxt_s.hold        = pm_data;
              nxt_s.instr_valid = 1'b0;
              nxt_s.pm_addr     = tbl_addr;
              nxt_s.tbl_busy    = 1'b1;
              nxt_s.tbl_dst     = cmd.daddr;
            end
            default:
              irq_ok = 1'b1;
          endcase
          // a full stack leaves the request pending at its source
          if (irq_ok && !pcl_wr && (ack != '0) && !stk_full)
          begin
            stk_push      = 1'b1;
            xfer          = 1'b1;
            xfer_pc       = vec;
            nxt_s.irq_ack = ack;
          end
          if (xfer)
          begin
            nxt_s.pc          = xfer_pc;
            nxt_s.pm_addr     = xfer_pc;
            nxt_s.instr_valid = 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all-zero reset puts the counter at the reset vector
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_ff    <= '0;
      s_ff.pc <= VEC_RESET;
      s_ff.pm_addr <= VEC_RESET;
    end
    else if (ce)
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pm_addr     = s_ff.pm_addr;
  assign instr       = s_ff.instr;
  assign instr_valid = s_ff.instr_valid;
  assign phase       = s_ff.phase;
  assign running     = sst_done;
  assign rd_data     = s_ff.rd_data;
  assign irq_ack     = s_ff.irq_ack;
  assign ram         = s_ff.ram;

endmodule
`default_nettype wire

// ==== mps_sst.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_sst
  import mps_pkg::*;
#(
  parameter int CYCLES = SST_CYC
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic start,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } mps_sst_t;

  mps_sst_t s_ff;
  mps_sst_t nxt_s;

  // ----------------------------------------------------------------
  // start-up hold counter
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    if (start)
    begin
      nxt_s.cnt  = '0;
      nxt_s.done = 1'b0;
    end
    else if (!s_ff.done)
    begin
      nxt_s.cnt = s_ff.cnt + CNT_ONE;
      if (s_ff.cnt == CNT_LAST)
        nxt_s.done = 1'b1;
    end
  end

  // reset itself counts as power-up, so the hold runs from here too
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_ff <= '0;
    else if (ce)
      s_ff <= nxt_s;
  end

  assign done = s_ff.done;

endmodule
`default_nettype wire

// ==== mps_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
module mps_stack
  import mps_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] din,
  output logic [PC_W-1:0]      top,
  output logic                 full
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] ent;
    logic [CW-1:0]              cnt;
  } mps_stk_t;

  mps_stk_t s_ff;
  mps_stk_t nxt_s;

  // ----------------------------------------------------------------
  // shift stack, entry 0 is the newest
  // ----------------------------------------------------------------
  // a shift keeps no pointer arithmetic; the oldest falls off the far end
  always_comb
  begin
    nxt_s = s_ff;
    if (push)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        nxt_s.ent[i] = s_ff.ent[i-1];
      nxt_s.ent[0] = din;
      if (s_ff.cnt != CNT_FULL)
        nxt_s.cnt = s_ff.cnt + CNT_ONE;
    end
    else if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        nxt_s.ent[i] = s_ff.ent[i+1];
      if (s_ff.cnt != '0)
        nxt_s.cnt = s_ff.cnt - CNT_ONE;
    end
  end

  // registers; reset empties the stack and zeroes the count
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_ff <= '0;
    else if (ce)
      s_ff <= nxt_s;
  end

  assign top  = s_ff.ent[0];
  assign full = (s_ff.cnt == CNT_FULL);

endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import mps_pkg::*;
;
  logic             clk, rst_n, ce, wake, instr_valid, running;
  mps_cmd_t         cmd;
  logic [IRQ_N-1:0] irq_pend, irq_ack;
  logic [IW-1:0]    pm_data, instr, w;
  logic [DW-1:0]    ram_rdata, rd_data, tp, v;
  logic [PC_W-1:0]  pm_addr, pa, ta;
  logic [1:0]       phase;
  mps_ram_t         ram;
  int               mismatches, tests_run, seed, n;
  logic [11:0]      stk[$];
  logic [6:0]       ra [5] = '{A_MP0, A_MP1, A_BANK, A_WREG, A_TABLE_POINTER};

  mps_sequencer #(.SST_CYCLES(8)) uut (.clk, .rst_n, .ce, .wake, .cmd, .irq_pend, .pm_data, .ram_rdata,
    .pm_addr, .instr, .instr_valid, .phase, .running, .rd_data, .irq_ack, .ram);
  mps_mem_model mem (.clk, .pm_addr, .ram, .pm_data, .ram_rdata);

  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // program word pattern held by the memory model
  function automatic logic [14:0] pmw(input logic [11:0] a);
    return {a[2:0] ^ 3'h5, a};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // falling edge after the next boundary
  task automatic wait_cyc;
    @(negedge clk);
    while (phase !== 2'h0)
      @(negedge clk);
  endtask

  // enabled edges until the start-up hold ends
  task automatic hold_chk;
    n = 0;
    while (running !== 1'b1)
    begin
      @(negedge clk);
      n++;
    end
    cmp(16'(n), 16'h0008, "hold");
  endtask

  // one instruction against the reference; entered at a cycle start, leaves at one
  task automatic run(input mps_cmd_t c, input logic [3:0] ip);
    logic [11:0] np, f;
    logic [3:0]  e;
    logic        d;
    cmd = c;
    irq_pend = ip;
    e = 4'h0;
    d = 1'b1;
    if (ip != 4'h0 && c.op == OP_NONE && !(c.wr && c.daddr == A_PCL) && stk.size() < 4)
      e = ip & ~(ip - 4'h1);
    if (e != 4'h0)
    begin
      stk.push_back(pa);
      np = e[0] ? VEC_EXT : e[1] ? VEC_TMR0 : e[2] ? VEC_TMR1 : VEC_CONV;
    end
    else if (c.wr && c.daddr == A_PCL)
      np = {pa[11:8], c.wdata};
    else
      case (c.op)
        OP_JUMP: np = c.target;
        OP_CALL:
        begin
          if (stk.size() == 4)
            void'(stk.pop_front());
          stk.push_back(pa);
          np = c.target;
        end
        OP_RET, OP_RETURN_FROM_INTERRUPT: np = stk.pop_back();
        OP_SKIP: np = pa + PC_ONE;
        OP_TRD_CUR: np = {pa[11:8], tp};
        OP_TRD_LAST: np = {LAST_PAGE, tp};
        default:
        begin
          np = pa + PC_ONE;
          d = 1'b0;
        end
      endcase
    f = (c.op inside {OP_TRD_CUR, OP_TRD_LAST}) ? pa : np;
    wait_cyc();
    cmp(irq_ack, e, "ack");
    cmp(pm_addr, np, "addr");
    cmp(instr_valid, !d, "valid");
    if (!d)
      cmp(instr, pmw(pa), "word");
    pa = np;
    if (d)
    begin
      irq_pend = 4'h0;
      wait_cyc();
      cmp(instr, pmw(f), "word");
      pa = f + PC_ONE;
      cmp(pm_addr, pa, "addr");
    end
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    run('{OP_NONE, 12'h000, 1'b1, 1'b0, a, 8'h00}, 4'h0);
    cmp(rd_data, x, "read");
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] x);
    run('{OP_NONE, 12'h000, 1'b0, 1'b1, a, x}, 4'h0);
  endtask

  task automatic ctl(input mps_op_t o, input logic [11:0] t, input logic [6:0] a);
    run('{o, t, 1'b0, 1'b0, a, 8'h00}, 4'h0);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h543b;
    mismatches = 0;
    tests_run = 0;
    {rst_n, wake, ce} = 3'b001;
    cmd = '0;
    irq_pend = 4'h0;
    tp = 8'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    cmp(pm_addr, VEC_RESET, "reset addr");
    hold_chk();
    wait_cyc();
    while (instr_valid !== 1'b1)
      wait_cyc();
    cmp(instr, pmw(VEC_RESET), "first word");
    pa = 12'h001;
    $display("done: reset");
    repeat (4) ctl(OP_NONE, 12'h000, 7'h00);
    n = $random(seed);
    ctl(OP_JUMP, {n[11:8], 2'b01, n[5:0]}, 7'h00);
    ctl(OP_SKIP, 12'h000, 7'h00);
    wr(A_PCL, {2'b01, n[21:16]});
    rd(A_PCL, pa[7:0] - 8'h01);
    $display("done: sequencing");
    // pointers are seven bits wide, the rest eight
    for (int i = 0; i < 5; i++)
    begin
      n = $random(seed);
      v = n[7:0];
      wr(ra[i], v);
      rd(ra[i], i < 2 ? {1'b0, v[6:0]} : v);
    end
    tp = v;
    wr(A_TABLE_HIGH_LATCH, 8'h5A);
    rd(A_TABLE_HIGH_LATCH, 8'h00);
    wr(7'h0A, 8'hFF);
    rd(7'h0A, 8'h00);
    $display("done: registers");
    for (int i = 0; i < 2; i++)
    begin
      ta = {(i == 0) ? pa[11:8] : LAST_PAGE, tp};
      w = pmw(ta);
      ctl(mps_op_t'(i == 0 ? OP_TRD_CUR : OP_TRD_LAST), 12'h000, 7'(33 + i));
      rd(7'(33 + i), w[7:0]);
      rd(A_TABLE_HIGH_LATCH, {1'b0, w[14:8]});
    end
    $display("done: table");
    v = n[15:8];
    wr(A_MP0, 8'h30);
    wr(A_IND0, v);
    rd(7'h30, v);
    wr(A_BANK, BANK_DISP);
    wr(A_MP1, 8'h45);
    wr(A_IND1, ~v);
    wr(7'h45, v);
    cmp(mem.b1[7'h45], 8'(~v), "display bank");
    rd(A_IND1, ~v);
    rd(7'h45, v);
    wr(A_MP0, 8'h02);
    rd(A_IND0, 8'h00);
    $display("done: indirect");
    for (int i = 1; i < 6; i++)
      ctl(OP_CALL, 12'(i * 12'h210 + 12'h030), 7'h00);
    run('{OP_NONE, 12'h000, 1'b0, 1'b0, 7'h00, 8'h00}, 4'h1);
    ctl(OP_RET, 12'h000, 7'h00);
    run('{OP_NONE, 12'h000, 1'b0, 1'b0, 7'h00, 8'h00}, 4'h1);
    ctl(OP_RETURN_FROM_INTERRUPT, 12'h000, 7'h00);
    repeat (3) ctl(OP_RET, 12'h000, 7'h00);
    $display("done: stack");
    for (int i = 0; i < 4; i++)
    begin
      run('{OP_NONE, 12'h000, 1'b0, 1'b0, 7'h00, 8'h00}, 4'(4'hF << i));
      ctl(OP_RET, 12'h000, 7'h00);
    end
    $display("done: interrupts");
    // freeze, then a wake restarts the hold
    ce = 1'b0;
    repeat (5) @(negedge clk);
    cmp({phase, pm_addr}, {2'h0, pa}, "frozen");
    {ce, wake} = 2'b11;
    @(negedge clk);
    wake = 1'b0;
    hold_chk();
    $display("done: wake");
    test_done();
  end

  // whole sequence needs some 400 clocks; fifty times that is a hang
  initial
  begin
    #80000;
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
